// File: common/crac_defs.vh
// Constants for the CR oscillation converter counter block
`ifndef CRAC_DEFS_VH
`define CRAC_DEFS_VH
`define CRAC_CNT_W 16
`define CRAC_CNT_MAX 16'hffff
`define CRAC_CNT_ZERO 16'h0000
`define CRAC_INIT_RST 16'h0bb8
`define CRAC_SYS_KHZ_LO 32
`define CRAC_SYS_KHZ_HI 64
`define CRAC_ST_IDLE 6'h01
`define CRAC_ST_ARM 6'h02
`define CRAC_ST_UPC 6'h04
`define CRAC_ST_STOP 6'h08
`define CRAC_ST_SEN 6'h10
`define CRAC_ST_DONE 6'h20
`endif

// File: hdl/crac_counters.v
// Counter logic of the CR oscillation resistance-to-digital converter
// Behaviour
// - Software supplies the initial value loaded into the up counter before the reference phase.
// - The 16-bit up-down counter counts system ticks upward in the reference phase, held at 65535.
// - The 16-bit up counter counts sensor edges in the sensor phase, held at 65535.
// - After run is set, the first falling sense edge enables the up counter and counting starts on the next.
// - The first falling tick after the up counter is enabled enables the up-down counter, counting from the next.
// - When the up counter rolls over from its maximum to zero it is disabled and the reference count ends.
// - After the up counter stops, the next falling tick disables the up-down counter.
// - In the sensor phase the up-down counter counts down from its reference value with the same edge timing.
// - At the end the up counter holds the sensor count, the edges from initial value to rollover times reference over sensor resistance.
// - The up-down counter advances on the system clock tick, which is 32 kHz or 64 kHz.
// - One sense input stage serves both oscillations so the oscillation constant cancels.
`include "crac_defs.vh"
module crac_counters #(
    parameter CNT_W = `CRAC_CNT_W
) (
    clk,
    arst_n,
    run,
    init_val,
    sense_in,
    sys_tick,
    fast_clk_sel,
    ref_sel,
    th_sel,
    busy,
    done,
    result,
    updn_val
);
    input wire clk;
    input wire arst_n;
    input wire run;
    input wire [CNT_W-1:0] init_val;
    input wire sense_in;
    input wire sys_tick;
    input wire fast_clk_sel;
    output reg ref_sel;
    output reg th_sel;
    output reg busy;
    output reg done;
    output reg [CNT_W-1:0] result;
    output reg [CNT_W-1:0] updn_val;

    localparam [5:0] ST_IDLE = `CRAC_ST_IDLE;
    localparam [5:0] ST_ARM = `CRAC_ST_ARM;
    localparam [5:0] ST_UPC = `CRAC_ST_UPC;
    localparam [5:0] ST_STOP = `CRAC_ST_STOP;
    localparam [5:0] ST_SEN = `CRAC_ST_SEN;
    localparam [5:0] ST_DONE = `CRAC_ST_DONE;
    localparam [CNT_W-1:0] MAXV = `CRAC_CNT_MAX;
    localparam [CNT_W-1:0] ZERO = `CRAC_CNT_ZERO;

    // Both pins pass two flops before the edge detector reads them
    wire s_fall;
    wire t_fall;

    reg [5:0] st_q;
    reg [5:0] st_d;
    reg sensor_q;
    reg sensor_d;
    reg up_en_q;
    reg up_en_d;
    reg up_stop_q;
    reg up_stop_d;
    reg ud_en_q;
    reg ud_en_d;
    reg ud_run_q;
    reg ud_run_d;
    // Rate choice is registered but drives nothing; the tick itself arrives on its own pin
    reg fast_q;
    reg fast_d;
    reg [CNT_W-1:0] up_q;
    reg [CNT_W-1:0] up_d;
    reg [CNT_W-1:0] ud_q;
    reg [CNT_W-1:0] ud_d;
    reg ref_sel_d;
    reg th_sel_d;
    reg busy_d;
    reg done_d;

    // One shared input stage for both resistors, so the oscillation constant cancels
    crac_fall_sync #(
        .IDLE_LVL(1'b1)
    ) u_sense_sync (
        .clk(clk),
        .arst_n(arst_n),
        .pin(sense_in),
        .fall(s_fall)
    );

    crac_fall_sync #(
        .IDLE_LVL(1'b1)
    ) u_tick_sync (
        .clk(clk),
        .arst_n(arst_n),
        .pin(sys_tick),
        .fall(t_fall)
    );

    // Counter events, decoded once so the state logic reads as the phases do
    wire up_live = up_en_q & ~up_stop_q;
    wire up_step = s_fall & up_live;
    wire up_wrap = up_step & ~sensor_q & (up_q == MAXV);
    wire up_full = up_q == MAXV;
    wire ud_arm = t_fall & ~ud_en_q & up_en_q;
    // Taken even if the up-down counter never armed, so a slow tick cannot hang the phase
    wire ref_over = t_fall & up_stop_q & ~sensor_q;
    wire ud_step = t_fall & ud_en_q & ~ref_over;
    wire ud_full = ud_q == MAXV;
    wire ud_empty = ud_q == ZERO;
    wire sen_over = sensor_q & ud_run_q & ud_empty;

    // Next state: every register keeps its value unless a phase event moves it
    always @* begin
        st_d = st_q;
        sensor_d = sensor_q;
        up_en_d = up_en_q;
        up_stop_d = up_stop_q;
        ud_en_d = ud_en_q;
        ud_run_d = ud_run_q;
        fast_d = fast_q;
        up_d = up_q;
        ud_d = ud_q;
        ref_sel_d = ref_sel;
        th_sel_d = th_sel;
        busy_d = busy;
        done_d = done;
        case (st_q)
            ST_IDLE: begin
                // A start is taken only here, so run is ignored while busy
                if (run) begin
                    up_d = init_val;
                    ud_d = ZERO;
                    fast_d = fast_clk_sel;
                    sensor_d = 1'b0;
                    ref_sel_d = 1'b1;
                    th_sel_d = 1'b0;
                    busy_d = 1'b1;
                    done_d = 1'b0;
                    st_d = ST_ARM;
                end
            end
            ST_ARM: begin
                // First falling sense edge only arms the up counter
                if (s_fall) begin
                    up_en_d = 1'b1;
                    up_stop_d = 1'b0;
                    ud_en_d = 1'b0;
                    ud_run_d = 1'b0;
                    st_d = sensor_q ? ST_SEN : ST_UPC;
                end
            end
            ST_UPC: begin
                if (up_step) begin
                    up_d = up_q + 1'b1;
                end
                if (up_wrap) begin
                    up_stop_d = 1'b1;
                    up_en_d = 1'b0;
                end
                if (ud_arm) begin
                    ud_en_d = 1'b1;
                end
                if (ref_over) begin
                    ud_en_d = 1'b0;
                    ud_run_d = 1'b0;
                    st_d = ST_STOP;
                end
                if (ud_step) begin
                    ud_run_d = 1'b1;
                    if (!ud_full) begin
                        ud_d = ud_q + 1'b1;
                    end
                end
            end
            ST_SEN: begin
                // Saturates so a fast sensor cannot wrap the result
                if (up_step && !up_full) begin
                    up_d = up_q + 1'b1;
                end
                if (ud_arm) begin
                    ud_en_d = 1'b1;
                end
                if (ud_step) begin
                    ud_run_d = 1'b1;
                    if (!ud_empty) begin
                        ud_d = ud_q - 1'b1;
                    end
                end
                if (sen_over) begin
                    up_en_d = 1'b0;
                    ud_en_d = 1'b0;
                    ud_run_d = 1'b0;
                    st_d = ST_DONE;
                end
            end
            ST_STOP: begin
                // Sensor phase restarts the up counter from zero on the thermistor path
                up_d = ZERO;
                sensor_d = 1'b1;
                up_stop_d = 1'b0;
                ref_sel_d = 1'b0;
                th_sel_d = 1'b1;
                st_d = ST_ARM;
            end
            ST_DONE: begin
                // Done stands until run is lowered and a new start is taken
                ref_sel_d = 1'b0;
                th_sel_d = 1'b0;
                busy_d = 1'b0;
                done_d = 1'b1;
                if (!run) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                // An illegal code falls back to idle
                st_d = ST_IDLE;
            end
        endcase
    end

    // Phase state and both counters
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= ST_IDLE;
            sensor_q <= 1'b0;
            up_en_q <= 1'b0;
            up_stop_q <= 1'b0;
            ud_en_q <= 1'b0;
            ud_run_q <= 1'b0;
            fast_q <= 1'b0;
            up_q <= ZERO;
            ud_q <= ZERO;
        end else begin
            st_q <= st_d;
            sensor_q <= sensor_d;
            up_en_q <= up_en_d;
            up_stop_q <= up_stop_d;
            ud_en_q <= ud_en_d;
            ud_run_q <= ud_run_d;
            fast_q <= fast_d;
            up_q <= up_d;
            ud_q <= ud_d;
        end
    end

    // Outputs are registered copies, so both counters show one cycle late
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ref_sel <= 1'b0;
            th_sel <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            result <= ZERO;
            updn_val <= ZERO;
        end else begin
            ref_sel <= ref_sel_d;
            th_sel <= th_sel_d;
            busy <= busy_d;
            done <= done_d;
            result <= up_q;
            updn_val <= ud_q;
        end
    end
endmodule // crac_counters

// Two-flop synchroniser for a pin, with a one-cycle strobe on each falling edge
module crac_fall_sync #(
    parameter [0:0] IDLE_LVL = 1'b1
) (
    clk,
    arst_n,
    pin,
    fall
);
    input wire clk;
    input wire arst_n;
    input wire pin;
    output wire fall;

    reg meta_q;
    reg sync_q;
    reg last_q;

    // Reset to the idle level of the pin so that no false edge follows reset
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= IDLE_LVL;
            sync_q <= IDLE_LVL;
            last_q <= IDLE_LVL;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    // The second flop and the third flop that copies it feed the edge detector
    assign fall = last_q & ~sync_q;
endmodule // crac_fall_sync

// File: sim/crac_checker.sv
// Concurrent checks on the converter counter ports
module crac_checker #(parameter CNT_W = 16) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ref_sel,
    input wire logic th_sel,
    input wire logic busy,
    input wire logic done,
    input wire logic [CNT_W-1:0] result,
    input wire logic [CNT_W-1:0] updn_val
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence ref_end;
        $fell(ref_sel) && busy;
    endsequence
    start_ref_a: assert property ($rose(busy) |-> ref_sel && !th_sel) else $error("bad start");
    sel_excl_a: assert property (!(ref_sel && th_sel)) else $error("both selected");
    up_step_a: assert property (ref_sel && $past(ref_sel, 2) && $changed(result)
        |-> (result - $past(result)) == 16'h0001) else $error("up step");
    ud_up_a: assert property (ref_sel && $past(ref_sel, 2)
        |-> updn_val >= $past(updn_val)) else $error("updown fell");
    ud_down_a: assert property (th_sel && $past(th_sel, 2)
        |-> updn_val <= $past(updn_val)) else $error("updown rose");
    ud_cap_a: assert property (ref_sel && updn_val == 16'hffff |=> updn_val == 16'hffff)
        else $error("updown wrap");
    up_cap_a: assert property (th_sel && result == 16'hffff |=> result == 16'hffff)
        else $error("up wrap");
    phase_next_a: assert property (ref_end |-> ##[0:200] th_sel) else $error("no sensor");
    done_zero_a: assert property ($rose(done) |-> ##[0:1] updn_val == 16'h0000)
        else $error("updown not zero");
    done_idle_a: assert property (done |-> !busy && !ref_sel && !th_sel)
        else $error("done while busy");
endmodule // crac_checker
bind crac_counters crac_checker #(.CNT_W(CNT_W)) chk (.clk(clk), .arst_n(arst_n),
    .ref_sel(ref_sel), .th_sel(th_sel), .busy(busy), .done(done), .result(result),
    .updn_val(updn_val));

// File: sim/crac_rc_net.sv
// Oscillating resistor network feeding the sense pin
module crac_rc_net (
    input wire logic ref_sel,
    input wire logic th_sel,
    input wire logic [7:0] ref_half,
    input wire logic [7:0] th_half,
    output logic sense_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // One shared node for both resistors; it rests high while nothing oscillates
    always begin
        sense_in = 1'b1;
        wait (ref_sel || th_sel);
        // Keep every pin edge clear of the clock edge that launched the select
        #5;
        while (ref_sel || th_sel) begin
            #(25 * (ref_sel ? ref_half : th_half));
            sense_in = !sense_in;
        end
    end
endmodule // crac_rc_net

// File: sim/tb_cr_oscillation_adc_counters.sv
// Testbench of the converter counter block
module tb_cr_oscillation_adc_counters;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, arst_n = 0, run = 0, sys_tick = 1, fast_clk_sel = 0;
    logic [15:0] init_val = 16'hffc0;
    logic [7:0] rh = 8'h08, th = 8'h08;
    wire sense_in, ref_sel, th_sel, busy, done;
    wire [15:0] result, updn_val;
    integer seed = 32'heebbe2ae, miscompares = 0, compares = 0, n, i, k, want;
    initial forever #12.5 clk = ~clk;
    // Tick is scaled to 8 clocks so a conversion stays short
    always begin
        repeat (4) @(negedge clk);
        sys_tick <= ~sys_tick;
    end
    crac_rc_net net (.ref_sel(ref_sel), .th_sel(th_sel), .ref_half(rh), .th_half(th),
        .sense_in(sense_in));
    crac_counters uut (.clk(clk), .arst_n(arst_n), .run(run), .init_val(init_val),
        .sense_in(sense_in), .sys_tick(sys_tick), .fast_clk_sel(fast_clk_sel),
        .ref_sel(ref_sel), .th_sel(th_sel), .busy(busy), .done(done), .result(result),
        .updn_val(updn_val));
    task results;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Edge alignment of both counters allows a few counts of slack
    task cmp_near(input logic [15:0] got, input integer exp);
        compares++;
        if ($isunknown(got) || got + 4 < exp || got > exp + 4) begin
            miscompares++;
            $display("unexpected %0t result %0d want %0d", $time, got, exp);
        end
    endtask
    task cmp_val(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %0t value %h want %h", $time, got, exp);
        end
    endtask
    initial begin
        #(25 * 60000);
        miscompares++;
        results;
    end
    initial begin
        repeat (5) @(negedge clk);
        arst_n = 1;
        for (i = 0; i < 4; i++) begin
            n = 16 + $unsigned($random(seed)) % 48;
            th = 8'(4 + $unsigned($random(seed)) % 16);
            fast_clk_sel = 1'($random(seed));
            init_val = 16'(65536 - n);
            run = 1;
            // Done from the last conversion stands until this start is taken
            @(negedge clk);
            cmp_val({15'h0000, busy}, 16'h0001);
            k = 0;
            while (done !== 1'b1 && k < 20000) begin
                @(negedge clk);
                k++;
            end
            if (k >= 20000)
                miscompares++;
            want = n * rh / th;
            cmp_near(result, want);
            cmp_val(updn_val, 16'h0000);
            cmp_val({13'h0000, busy, ref_sel, th_sel}, 16'h0000);
            run = 0;
            repeat (3) @(negedge clk);
        end
        results;
    end
endmodule // tb_cr_oscillation_adc_counters
